// file: core/lgp_pkg.sv
package lgp_pkg;

    // Printed offsets are register indexes; byte address is four times that
    localparam logic [7:0] LINE0_DIR_IDX = 8'h1d;
    localparam logic [7:0] LINE21_DIR_IDX = 8'h1e;
    localparam logic [7:0] LINE3_OUT4_IDX = 8'h1f;
    localparam logic [7:0] OUT65_IDX = 8'h20;
    localparam logic [7:0] OUT87_IDX = 8'h21;
    localparam logic [7:0] STATUS_IDX = 8'h22;
    localparam int CFG_COUNT = 5;
    localparam int ADDR_W = 12;

    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Field positions inside each nibble of a configuration register
    localparam int NIB_EN_BIT = 0;
    localparam int NIB_BACK_BIT = 1;
    localparam int NIB_FWD_BIT = 2;
    localparam int NIB_VAL_BIT = 3;

    // Status register layout
    localparam int ST_MODE18_BIT = 0;
    localparam int ST_LOCK_BIT = 1;
    localparam int ST_IN_POS = 4;
    localparam int ST_FWD_POS = 8;

    function automatic logic lgp_line_is_fwd(input logic [3:0] nib);
        lgp_line_is_fwd = nib[NIB_EN_BIT] & nib[NIB_FWD_BIT]
            & ~nib[NIB_BACK_BIT];
    endfunction

    function automatic logic lgp_line_is_back(input logic [3:0] nib);
        lgp_line_is_back = nib[NIB_EN_BIT] & nib[NIB_BACK_BIT]
            & ~nib[NIB_FWD_BIT];
    endfunction

    function automatic logic [ADDR_W-1:0] lgp_byte_addr(input logic [7:0] idx);
        lgp_byte_addr = ADDR_W'({idx, 2'b00});
    endfunction

endpackage

// file: core/lgp_pin_sync.sv
`timescale 1ns/10ps
// Three-stage pin synchroniser; output moves only when stages two and three agree
module lgp_pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] level_next;

    always_comb
    begin
        level_next = level_reg;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (s2_reg[i] == s3_reg[i])
            begin
                level_next[i] = s3_reg[i];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            level_reg <= '0;
        end
        else
        begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level_out = level_reg;
endmodule

// file: core/lgp_gpio_top.sv
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
// Functional notes
// - In 18-bit mode R1,R0,G1,G0 become four lines, forward out or back in.
// - 18-bit mode is taken from the remote serializer, never set locally.
// - Register 0x1F low nibble: 0x5 forward output, 0x3 back input, line 3.
// - 0x1E nibbles steer lines 2 and 1; 0x1D low nibble steers line 0.
// - Register-driven pins 8..4 are outputs set only by local writes.
// - Register 0x21: upper nibble pin 8, lower pin 7; bit0 enable, bit3 value.
// - Register 0x20 steers pins 6 and 5; 0x1F upper nibble steers pin 4.
// - Power-down low floats outputs; else output enable and state select apply.
module lgp_gpio_top #(
    parameter int LINES = 4,
    parameter int OUTS = 5
) (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [lgp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [lgp_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Link side, same clock
    input wire logic link_mode18,
    input wire logic link_locked,
    input wire logic fwd_frame_valid,
    input wire logic [LINES-1:0] fwd_gpio,
    output logic [LINES-1:0] back_gpio,
    // Pins
    input wire logic power_down_pin,
    input wire logic output_enable_pin,
    input wire logic output_state_select,
    input wire logic [LINES-1:0] gpio_in,
    output logic [LINES-1:0] gpio_out,
    output logic [LINES-1:0] gpio_oe_n,
    output logic [OUTS-1:0] reg_driven_outputs,
    output logic [OUTS-1:0] reg_driven_oe_n
);
    localparam int NIBS = 2 * lgp_pkg::CFG_COUNT;

    // Pin synchronisation
    logic [LINES+2:0] pins_sync;
    logic pdb_s;
    logic oen_s;
    logic oss_s;
    logic [LINES-1:0] gpio_in_s;

    lgp_pin_sync #(
        .WIDTH(LINES + 3)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in({gpio_in, output_state_select, output_enable_pin,
            power_down_pin}),
        .level_out(pins_sync)
    );

    assign pdb_s = pins_sync[0];
    assign oen_s = pins_sync[1];
    assign oss_s = pins_sync[2];
    assign gpio_in_s = pins_sync[LINES+2:3];

    // Configuration registers
    logic [7:0] cfg_reg [lgp_pkg::CFG_COUNT];
    logic [7:0] cfg_next [lgp_pkg::CFG_COUNT];
    logic [4*NIBS-1:0] cfg_flat;

    always_comb
    begin
        for (int i = 0; i < lgp_pkg::CFG_COUNT; i++)
        begin
            cfg_flat[8*i +: 8] = cfg_reg[i];
        end
    end

    // AXI write channel
    logic aw_got_reg;
    logic aw_got_next;
    logic w_got_reg;
    logic w_got_next;
    logic [lgp_pkg::ADDR_W-1:0] awaddr_reg;
    logic [lgp_pkg::ADDR_W-1:0] awaddr_next;
    logic [7:0] wbyte_reg;
    logic [7:0] wbyte_next;
    logic wlane_reg;
    logic wlane_next;
    logic bvalid_reg;
    logic bvalid_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;
    logic do_write;
    logic [lgp_pkg::ADDR_W-1:0] wr_addr;
    logic wr_hit;

    assign s_axi_awready = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready = !w_got_reg && !bvalid_reg;

    always_comb
    begin
        aw_got_next = aw_got_reg;
        w_got_next = w_got_reg;
        awaddr_next = awaddr_reg;
        wbyte_next = wbyte_reg;
        wlane_next = wlane_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_got_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_got_next = 1'b1;
            wbyte_next = s_axi_wdata[7:0];
            wlane_next = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            bvalid_next = 1'b0;
        end
        if (aw_got_reg && w_got_reg)
        begin
            aw_got_next = 1'b0;
            w_got_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = wr_hit ? lgp_pkg::RESP_OKAY : lgp_pkg::RESP_SLVERR;
        end
    end

    // Writes land in the cycle after both halves are held
    assign do_write = aw_got_reg && w_got_reg;
    assign wr_addr = {awaddr_reg[lgp_pkg::ADDR_W-1:2], 2'b00};

    always_comb
    begin
        wr_hit = wr_addr == lgp_pkg::lgp_byte_addr(lgp_pkg::STATUS_IDX);
        for (int i = 0; i < lgp_pkg::CFG_COUNT; i++)
        begin
            cfg_next[i] = cfg_reg[i];
            if (wr_addr == lgp_pkg::lgp_byte_addr(
                8'(lgp_pkg::LINE0_DIR_IDX + 8'(i))))
            begin
                wr_hit = 1'b1;
                // Only local writes reach these bits; nothing from the link
                if (do_write && wlane_reg)
                begin
                    cfg_next[i] = wbyte_reg;
                end
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= '0;
            wbyte_reg <= 8'h00;
            wlane_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= lgp_pkg::RESP_OKAY;
            for (int i = 0; i < lgp_pkg::CFG_COUNT; i++)
            begin
                cfg_reg[i] <= lgp_pkg::CFG_RESET;
            end
        end
        else
        begin
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            awaddr_reg <= awaddr_next;
            wbyte_reg <= wbyte_next;
            wlane_reg <= wlane_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            cfg_reg <= cfg_next;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // Line and output decode
    logic mode18;
    logic [LINES-1:0] line_fwd;
    logic [LINES-1:0] line_back;
    logic [OUTS-1:0] out_en;
    logic [OUTS-1:0] out_val;
    logic [LINES-1:0] fwd_val_reg;
    logic [LINES-1:0] fwd_val_next;
    logic [LINES-1:0] back_reg;
    logic [LINES-1:0] back_next;

    // Mode comes from the remote end only; no local register bit sets it
    assign mode18 = link_mode18;

    // Nibble of each line: line0 low 0x1D, line1 low 0x1E, line2 high 0x1E,
    // line3 low 0x1F. Upper nibble of 0x1D is don't-care.
    localparam int LINE_NIB [4] = '{0, 2, 3, 4};

    generate
        for (genvar g = 0; g < LINES; g++)
        begin : g_line
            logic [3:0] nib;
            assign nib = cfg_flat[4*LINE_NIB[g] +: 4];
            assign line_fwd[g] = mode18 && lgp_pkg::lgp_line_is_fwd(nib);
            assign line_back[g] = mode18 && lgp_pkg::lgp_line_is_back(nib);
        end
        // Outputs 4..8 follow nibbles 5..9; bit0 enables, bit3 is the level
        for (genvar g = 0; g < OUTS; g++)
        begin : g_out
            logic [3:0] nib;
            assign nib = cfg_flat[4*(g+5) +: 4];
            assign out_en[g] = mode18 && nib[lgp_pkg::NIB_EN_BIT];
            assign out_val[g] = nib[lgp_pkg::NIB_VAL_BIT];
        end
    endgenerate

    // Pin states: float, drive low, or drive live values
    logic float_all;
    logic live;
    logic [LINES-1:0] gpio_out_reg;
    logic [LINES-1:0] gpio_out_next;
    logic [LINES-1:0] gpio_oe_n_reg;
    logic [LINES-1:0] gpio_oe_n_next;
    logic [OUTS-1:0] rdo_reg;
    logic [OUTS-1:0] rdo_next;
    logic [OUTS-1:0] rdo_oe_n_reg;
    logic [OUTS-1:0] rdo_oe_n_next;

    assign float_all = !pdb_s || (!oen_s && oss_s);
    assign live = oen_s && oss_s && link_locked;

    always_comb
    begin
        fwd_val_next = fwd_val_reg;
        if (fwd_frame_valid)
        begin
            fwd_val_next = fwd_gpio;
        end
        back_next = gpio_in_s & line_back;
        for (int i = 0; i < LINES; i++)
        begin
            gpio_out_next[i] = 1'b0;
            gpio_oe_n_next[i] = 1'b1;
            if (!float_all && line_fwd[i])
            begin
                gpio_oe_n_next[i] = 1'b0;
                gpio_out_next[i] = live && fwd_val_reg[i];
            end
        end
        for (int i = 0; i < OUTS; i++)
        begin
            rdo_next[i] = 1'b0;
            rdo_oe_n_next[i] = 1'b1;
            if (!float_all && out_en[i])
            begin
                rdo_oe_n_next[i] = 1'b0;
                rdo_next[i] = live && out_val[i];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fwd_val_reg <= '0;
            back_reg <= '0;
            gpio_out_reg <= '0;
            gpio_oe_n_reg <= '1;
            rdo_reg <= '0;
            rdo_oe_n_reg <= '1;
        end
        else
        begin
            fwd_val_reg <= fwd_val_next;
            back_reg <= back_next;
            gpio_out_reg <= gpio_out_next;
            gpio_oe_n_reg <= gpio_oe_n_next;
            rdo_reg <= rdo_next;
            rdo_oe_n_reg <= rdo_oe_n_next;
        end
    end

    assign back_gpio = back_reg;
    assign gpio_out = gpio_out_reg;
    assign gpio_oe_n = gpio_oe_n_reg;
    assign reg_driven_outputs = rdo_reg;
    assign reg_driven_oe_n = rdo_oe_n_reg;

    // AXI read channel
    logic rvalid_reg;
    logic rvalid_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;
    logic [lgp_pkg::ADDR_W-1:0] rd_addr;

    assign s_axi_arready = !rvalid_reg;
    assign rd_addr = {s_axi_araddr[lgp_pkg::ADDR_W-1:2], 2'b00};

    always_comb
    begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_rvalid && s_axi_rready)
        begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_next = 1'b1;
            rdata_next = 32'h0000_0000;
            rresp_next = lgp_pkg::RESP_SLVERR;
            if (rd_addr == lgp_pkg::lgp_byte_addr(lgp_pkg::STATUS_IDX))
            begin
                rresp_next = lgp_pkg::RESP_OKAY;
                rdata_next[lgp_pkg::ST_MODE18_BIT] = mode18;
                rdata_next[lgp_pkg::ST_LOCK_BIT] = link_locked;
                rdata_next[lgp_pkg::ST_IN_POS +: LINES] = gpio_in_s;
                rdata_next[lgp_pkg::ST_FWD_POS +: LINES] = fwd_val_reg;
            end
            for (int i = 0; i < lgp_pkg::CFG_COUNT; i++)
            begin
                if (rd_addr == lgp_pkg::lgp_byte_addr(
                    8'(lgp_pkg::LINE0_DIR_IDX + 8'(i))))
                begin
                    rresp_next = lgp_pkg::RESP_OKAY;
                    rdata_next[7:0] = cfg_reg[i];
                end
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= lgp_pkg::RESP_OKAY;
        end
        else
        begin
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
endmodule

// file: bench/lgp_checker.sv
`timescale 1ns/10ps
module lgp_checker #(
    parameter int LINES = 4,
    parameter int OUTS = 5
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic link_mode18,
    input wire logic power_down_pin,
    input wire logic output_enable_pin,
    input wire logic output_state_select,
    input wire logic [LINES-1:0] gpio_out,
    input wire logic [LINES-1:0] gpio_oe_n,
    input wire logic [OUTS-1:0] reg_driven_outputs,
    input wire logic [OUTS-1:0] reg_driven_oe_n
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_write_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_all_float;
        (&gpio_oe_n) && (&reg_driven_oe_n);
    endsequence
    // Eight samples cover the three-stage pin synchroniser plus output flop
    a_write_answer: assert property (
        s_write_take |=> ##[0:2] s_axi_bvalid)
        else $error("write response late");
    a_write_busy: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while busy");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while busy");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_pd_float: assert property (!power_down_pin [*8] |-> s_all_float)
        else $error("pin driven in power down");
    a_oen_float: assert property (
        (!output_enable_pin && output_state_select) [*8] |-> s_all_float)
        else $error("pin driven with output disabled");
    a_oen_low: assert property (
        (power_down_pin && !output_enable_pin && !output_state_select) [*8]
        |-> (gpio_out & ~gpio_oe_n) == 0 && reg_driven_outputs == 0)
        else $error("pin not held low");
    a_mode_float: assert property (!link_mode18 [*4] |-> s_all_float)
        else $error("pin driven outside 18-bit mode");
endmodule
bind lgp_gpio_top lgp_checker #(.LINES(LINES), .OUTS(OUTS)) u_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .link_mode18, .power_down_pin, .output_enable_pin,
    .output_state_select, .gpio_out, .gpio_oe_n, .reg_driven_outputs,
    .reg_driven_oe_n);

// file: bench/lgp_remote_ser.sv
`timescale 1ns/10ps
module lgp_remote_ser (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic mode_set,
    input wire logic [3:0] tx_val,
    input wire logic [3:0] back_gpio,
    output logic link_mode18,
    output logic link_locked,
    output logic fwd_frame_valid,
    output logic [3:0] fwd_gpio,
    output logic [3:0] rx_val
);
    logic [4:0] cnt;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt <= 5'h00;
            link_locked <= 1'b0;
            link_mode18 <= 1'b0;
            fwd_frame_valid <= 1'b0;
            fwd_gpio <= 4'h0;
            rx_val <= 4'h0;
        end
        else
        begin
            cnt <= cnt + 5'h01;
            link_locked <= link_locked | (&cnt);
            link_mode18 <= mode_set;
            fwd_frame_valid <= cnt[2:0] == 3'h7;
            // Off-frame data inverted so a late sample is caught
            fwd_gpio <= (cnt[2:0] == 3'h7) ? tx_val : ~tx_val;
            rx_val <= back_gpio;
        end
    end
endmodule

// file: bench/link_gpio_and_reg_outputs_bench.sv
`timescale 1ns/10ps
module link_gpio_and_reg_outputs_bench;
    logic aclk = 0;
    logic aresetn = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0] wstrb = 0, tx_val = 0, gin = 0;
    logic mode_set = 0, pd = 1, oe = 1, oss = 1;
    logic awready, wready, bvalid, arready, rvalid, mode18, locked, fv;
    logic [1:0] bresp, rresp, r;
    logic [3:0] fwd, back, gout, goe_n, rxv;
    logic [4:0] rdo, rdo_oe_n;
    int err_count = 0, cmp_count = 0, cyc = 0, seed = 32'h91be;
    int cfg [5];
    logic [7:0] gv [4] = '{8'h90, 8'h10, 8'h09, 8'h01};
    always #2 aclk = ~aclk;
    lgp_gpio_top u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .link_mode18(mode18), .link_locked(locked),
        .fwd_frame_valid(fv), .fwd_gpio(fwd), .back_gpio(back),
        .power_down_pin(pd), .output_enable_pin(oe),
        .output_state_select(oss), .gpio_in(gin), .gpio_out(gout),
        .gpio_oe_n(goe_n), .reg_driven_outputs(rdo),
        .reg_driven_oe_n(rdo_oe_n));
    lgp_remote_ser u_ser (.aclk(aclk), .aresetn(aresetn),
        .mode_set(mode_set), .tx_val(tx_val), .back_gpio(back),
        .link_mode18(mode18), .link_locked(locked),
        .fwd_frame_valid(fv), .fwd_gpio(fwd), .rx_val(rxv));
    task automatic stop_test();
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_bus(input logic [31:0] g, input logic [31:0] e);
        cmp(g, e);
    endtask
    task automatic chk_pin(input logic [31:0] g, input logic [31:0] e);
        cmp(g, e);
    endtask
    // Ready is sampled mid-cycle so the edge that takes it needs no race
    task automatic wr(input logic [7:0] i, input logic [7:0] v,
        input logic [3:0] s);
        logic a, w, b;
        @(posedge aclk);
        awaddr <= {2'b00, i, 2'b00};
        wdata <= {24'h00_0000, v};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b = 1'b0;
        while (!b)
        begin
            @(negedge aclk);
            a = awready === 1'b1;
            w = wready === 1'b1;
            b = bvalid === 1'b1;
            r = bresp;
            @(posedge aclk);
            if (a)
                awvalid <= 1'b0;
            if (w)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] i);
        logic a, v;
        @(posedge aclk);
        araddr <= {2'b00, i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        v = 1'b0;
        while (!v)
        begin
            @(negedge aclk);
            a = arready === 1'b1;
            v = rvalid === 1'b1;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (a)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask
    task automatic set(input int i, input logic [7:0] v, input logic [3:0] s);
        wr(8'(8'h1d + i), v, s);
        chk_bus(r, lgp_pkg::RESP_OKAY);
        if (s[0])
            cfg[i] = v;
    endtask
    task automatic pins(input bit wb);
        logic [8:0] e_oe, e_v;
        logic [3:0] e_b, n;
        int j;
        bit drv, live, en;
        repeat (14) @(posedge aclk);
        // Sample mid-cycle, away from the edge that launches the outputs
        @(negedge aclk);
        drv = mode_set && pd && (oe || !oss);
        live = oe && oss && locked;
        for (int k = 0; k < 9; k++)
        begin
            j = k ? k + 1 : 0;
            n = 4'(cfg[j / 2] >> (4 * (j % 2)));
            en = k < 4 ? n[2:0] == 3'h5 : n[0];
            e_oe[k] = !(drv && en);
            e_v[k] = drv && en && live && (k < 4 ? tx_val[k] : n[3]);
            if (k < 4)
                e_b[k] = n[2:0] == 3'h3 && gin[k];
        end
        chk_pin({rdo_oe_n, goe_n}, e_oe);
        chk_pin({rdo, gout} & ~e_oe, e_v);
        if (wb)
        begin
            chk_pin(back, e_b);
            chk_pin(rxv, e_b);
        end
        @(posedge aclk);
    endtask
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            stop_test();
        end
    end
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            cfg[i] = 0;
            rd(8'(8'h1d + i));
            chk_bus(d, lgp_pkg::CFG_RESET);
        end
        pins(0);
        for (int i = 0; i < 5; i++)
        begin
            set(i, 8'($random(seed)), 4'hf);
            rd(8'(8'h1d + i));
            chk_bus(d, cfg[i]);
        end
        set(0, 8'h5a, 4'h0);
        rd(8'h1d);
        chk_bus(d, cfg[0]);
        wr(8'h30, 8'h01, 4'hf);
        chk_bus(r, lgp_pkg::RESP_SLVERR);
        rd(8'h30);
        chk_bus(d, 32'h0000_0000);
        chk_bus(r, lgp_pkg::RESP_SLVERR);
        for (int i = 0; i < 5; i++)
            set(i, 8'h00, 4'hf);
        mode_set <= 1'b1;
        for (int i = 2; i < 5; i++)
            for (int k = 0; k < 4; k++)
            begin
                set(i, gv[k], 4'hf);
                pins(0);
            end
        set(0, 8'h95, 4'hf);
        set(1, 8'h55, 4'hf);
        set(2, 8'h05, 4'hf);
        tx_val <= 4'($random(seed));
        pins(0);
        set(0, 8'h93, 4'hf);
        set(1, 8'h33, 4'hf);
        set(2, 8'h03, 4'hf);
        gin <= 4'($random(seed));
        pins(1);
        rd(8'h22);
        chk_bus(d, {20'h0_0000, tx_val, gin, 2'b00, 2'b11});
        set(0, 8'h95, 4'hf);
        set(1, 8'h50, 4'hf);
        set(4, 8'h99, 4'hf);
        tx_val <= 4'($random(seed));
        for (int k = 0; k < 8; k++)
        begin
            {pd, oe, oss} <= 3'(k);
            pins(0);
        end
        mode_set <= 1'b0;
        pins(0);
        stop_test();
    end
endmodule
